// ### hw/clk_ctrl_pkg.sv
// constants, field layout and helpers for the clock source and output select block
//
// Behaviour
// - five sources: fast external, 16 MHz RC, 48 MHz RC, 32.768 kHz external, 32 kHz RC
// - pll reference is either fast external oscillator or 16 MHz RC, nothing else
// - fast bypass bit takes clock straight from input pin, output pin left unused
// - slow external oscillator bypass bit in backup control register drives input pin directly
// - output a select: 00 fast RC, 01 slow crystal, 10 fast crystal, 11 pll p
// - output b select: 00 system clock, 01 audio pll r, 10 fast crystal, 11 pll p
// - clock output path samples sources on the bus clock; sources above half the bus clock alias
// - rtc on slow RC halts without main power, resumes from retained count
// - slow crystal drive strength set by software, including a high start-up setting
// - maximum system clock is 168, 200 or 240 MHz depending on variant
package clk_ctrl_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CLOCK_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CLOCK_CONFIG = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_BACKUP_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CAPS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_RTC_COUNT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;

  // clock_ctrl_reg fields
  localparam int CTRL_HS_EN = 0;
  localparam int CTRL_FAST_EN = 1;
  localparam int CTRL_USB_EN = 2;
  localparam int CTRL_HS_BYPASS = 3;
  localparam logic [3:0] CTRL_RESET = 4'h2;

  // clock_config_reg fields
  localparam int CFG_PLL_REF = 0;
  localparam int CFG_A_SEL_LO = 2;
  localparam int CFG_B_SEL_LO = 4;
  localparam int CFG_A_AF = 6;
  localparam int CFG_B_AF = 7;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // backup_clock_ctrl_reg fields
  localparam int BK_LS_EN = 0;
  localparam int BK_LS_BYPASS = 1;
  localparam int BK_DRIVE_LO = 2;
  localparam int BK_RTC_SRC_LO = 4;
  localparam int BK_SLOW_EN = 6;
  localparam logic [6:0] BK_RESET = 7'h00;

  // status register fields
  localparam int ST_READY_LO = 0;
  localparam int ST_POWER = 5;
  localparam int ST_HALTED = 6;

  // pll reference codes
  localparam logic PLL_REF_FAST_RC = 1'b0;
  localparam logic PLL_REF_HS_EXT = 1'b1;

  // output a codes
  localparam logic [1:0] A_SEL_FAST_RC = 2'h0;
  localparam logic [1:0] A_SEL_LS_EXT = 2'h1;
  localparam logic [1:0] A_SEL_HS_EXT = 2'h2;
  localparam logic [1:0] A_SEL_PLL_P = 2'h3;

  // output b codes
  localparam logic [1:0] B_SEL_SYS = 2'h0;
  localparam logic [1:0] B_SEL_AUDIO_R = 2'h1;
  localparam logic [1:0] B_SEL_HS_EXT = 2'h2;
  localparam logic [1:0] B_SEL_PLL_P = 2'h3;

  // rtc source codes
  localparam logic [1:0] RTC_SRC_NONE = 2'h0;
  localparam logic [1:0] RTC_SRC_LS_EXT = 2'h1;
  localparam logic [1:0] RTC_SRC_SLOW_RC = 2'h2;

  // slow crystal drive codes, highest helps start-up
  localparam logic [1:0] DRIVE_LOW = 2'h0;
  localparam logic [1:0] DRIVE_HIGH = 2'h3;

  // clock output range in kHz
  localparam int CLKOUT_MIN_KHZ = 32;
  localparam int CLKOUT_MAX_KHZ = 200000;

  // variant maximum system clock in MHz
  localparam logic [7:0] SYSCLK_MHZ_V0 = 8'ha8;
  localparam logic [7:0] SYSCLK_MHZ_V1 = 8'hc8;
  localparam logic [7:0] SYSCLK_MHZ_V2 = 8'hf0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [7:0] max_sysclk_mhz(input logic [1:0] variant);
    case (variant)
      2'h0: max_sysclk_mhz = SYSCLK_MHZ_V0;
      2'h1: max_sysclk_mhz = SYSCLK_MHZ_V1;
      default: max_sysclk_mhz = SYSCLK_MHZ_V2;
    endcase
  endfunction : max_sysclk_mhz

  // byte-lane merge of a write into a stored word
  function automatic logic [DATA_W-1:0] merge_strb(input logic [DATA_W-1:0] old_v,
                                                   input logic [DATA_W-1:0] new_v,
                                                   input logic [DATA_W/8-1:0] strb);
    merge_strb = old_v;
    for (int i = 0; i < DATA_W / 8; i++) begin
      if (strb[i]) begin
        merge_strb[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
  endfunction : merge_strb

endpackage : clk_ctrl_pkg

// ### hw/clkout_if.sv
// carrier between the controller and one clock output multiplexer
`timescale 1ns/100ps
interface clkout_if;
  logic [1:0] sel;
  logic pin_en;
  logic [3:0] src;
  logic pin_out;
  modport mux (input sel, input pin_en, input src, output pin_out);
  modport ctrl (output sel, output pin_en, output src, input pin_out);
endinterface : clkout_if

// ### hw/level_sync.sv
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/100ps
module level_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q <= '0;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : level_sync

// ### hw/clkout_mux.sv
// registered four-way clock output multiplexer with pin gate
`timescale 1ns/100ps
module clkout_mux (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // selection and sources
  clkout_if.mux port
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port.pin_out <= 1'b0;
    end else if (ce) begin
      // pin stays low unless in alternate function mode
      port.pin_out <= port.pin_en & port.src[port.sel];
    end
  end
endmodule : clkout_mux

// ### hw/clock_source_and_output_select.sv
// clock source control, clock output selection and rtc count behind an axi4-lite slave
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module clock_source_and_output_select
  import clk_ctrl_pkg::*;
#(
  parameter logic [1:0] VARIANT = 2'h0,
  parameter int RTC_W = 32
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W/8-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // oscillator pins and internal clocks, all asynchronous
  input wire logic hs_osc_input_pin,
  input wire logic ls_osc_input_pin,
  input wire logic rc_osc_fast,
  input wire logic rc_osc_usb_rate,
  input wire logic rc_osc_slow,
  input wire logic pll_p_output,
  input wire logic audio_pll_r_output,
  input wire logic system_clock,
  // oscillator ready levels: hs, fast rc, usb rc, ls, slow rc
  input wire logic [4:0] osc_ready,
  input wire logic main_power_good,
  // oscillator controls
  output logic [4:0] osc_enable,
  output logic hs_osc_output_pin_drive,
  output logic ls_osc_output_pin_drive,
  output logic [1:0] ls_drive_strength,
  output logic pll_ref_select,
  output logic hs_clock_from_pin,
  output logic ls_clock_from_pin,
  // clock output pins
  output logic clkout_a_pin_signal,
  output logic clkout_b_pin_signal
);

  ////////////////////////////////////////////////////////////////////////////////
  // synchronised inputs

  localparam int NSYNC = 14;
  logic [NSYNC-1:0] sync_q;
  logic hs_s, ls_s, fast_s, usb_s, slow_s, pllp_s, audio_s, sys_s, power_s;
  logic [4:0] ready_s;

  level_sync #(.WIDTH(NSYNC)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .d({main_power_good, osc_ready, system_clock, audio_pll_r_output, pll_p_output,
        rc_osc_slow, rc_osc_usb_rate, rc_osc_fast, ls_osc_input_pin, hs_osc_input_pin}),
    .q(sync_q)
  );

  assign {power_s, ready_s, sys_s, audio_s, pllp_s, slow_s, usb_s, fast_s, ls_s, hs_s} = sync_q;

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  logic [3:0] clock_ctrl_reg;
  logic [7:0] clock_config_reg;
  logic [6:0] backup_clock_ctrl_reg;
  logic [RTC_W-1:0] rtc_count;
  logic rtc_halted;

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path

  logic aw_held, w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [DATA_W/8-1:0] w_strb;
  logic aw_take, w_take, do_write;
  logic next_aw_held, next_w_held, next_bvalid;

  assign aw_take = awvalid & awready;
  assign w_take = wvalid & wready;
  assign do_write = aw_held & w_held & ~bvalid;

  always_comb begin
    next_aw_held = aw_take | (aw_held & ~do_write);
    next_w_held = w_take | (w_held & ~do_write);
    next_bvalid = do_write | (bvalid & ~bready);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else if (ce) begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      // one write at a time: no new address or data until the response is taken
      awready <= ~next_aw_held & ~next_bvalid;
      wready <= ~next_w_held & ~next_bvalid;
      bvalid <= next_bvalid;
      if (aw_take) begin
        aw_addr <= awaddr;
      end
      if (w_take) begin
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (do_write) begin
        bresp <= write_ok(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  function automatic logic write_ok(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_CLOCK_CTRL, OFS_CLOCK_CONFIG, OFS_BACKUP_CTRL, OFS_RTC_COUNT, OFS_STATUS: write_ok = 1'b1;
      default: write_ok = 1'b0;
    endcase
  endfunction : write_ok

  function automatic logic hit(input logic [ADDR_W-1:0] ofs);
    hit = do_write && aw_addr == ofs;
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////////
  // control registers

  logic [DATA_W-1:0] ctrl_w, cfg_w, bk_w, rtc_w, st_w;

  always_comb begin
    ctrl_w = merge_strb(DATA_W'(clock_ctrl_reg), w_data, w_strb);
    cfg_w = merge_strb(DATA_W'(clock_config_reg), w_data, w_strb);
    bk_w = merge_strb(DATA_W'(backup_clock_ctrl_reg), w_data, w_strb);
    rtc_w = merge_strb(DATA_W'(rtc_count), w_data, w_strb);
    st_w = w_data & {{(DATA_W-8){1'b0}}, w_strb[0] ? 8'hff : 8'h00};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_ctrl_reg <= CTRL_RESET;
    end else if (ce && hit(OFS_CLOCK_CTRL)) begin
      clock_ctrl_reg <= ctrl_w[3:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_config_reg <= CFG_RESET;
    end else if (ce && hit(OFS_CLOCK_CONFIG)) begin
      clock_config_reg <= cfg_w[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      backup_clock_ctrl_reg <= BK_RESET;
    end else if (ce && hit(OFS_BACKUP_CTRL)) begin
      backup_clock_ctrl_reg <= bk_w[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // oscillator control outputs

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_enable <= '0;
      hs_osc_output_pin_drive <= 1'b0;
      ls_osc_output_pin_drive <= 1'b0;
      hs_clock_from_pin <= 1'b0;
      ls_clock_from_pin <= 1'b0;
      ls_drive_strength <= DRIVE_LOW;
      pll_ref_select <= PLL_REF_FAST_RC;
    end else if (ce) begin
      osc_enable <= {backup_clock_ctrl_reg[BK_SLOW_EN], backup_clock_ctrl_reg[BK_LS_EN],
                     clock_ctrl_reg[CTRL_USB_EN], clock_ctrl_reg[CTRL_FAST_EN],
                     clock_ctrl_reg[CTRL_HS_EN]};
      // in bypass the crystal amplifier is off and the output pin floats
      hs_osc_output_pin_drive <= clock_ctrl_reg[CTRL_HS_EN] & ~clock_ctrl_reg[CTRL_HS_BYPASS];
      hs_clock_from_pin <= clock_ctrl_reg[CTRL_HS_BYPASS];
      ls_osc_output_pin_drive <= backup_clock_ctrl_reg[BK_LS_EN] &
                                 ~backup_clock_ctrl_reg[BK_LS_BYPASS];
      ls_clock_from_pin <= backup_clock_ctrl_reg[BK_LS_BYPASS];
      ls_drive_strength <= backup_clock_ctrl_reg[BK_DRIVE_LO +: 2];
      // single bit: only the two legal references can be chosen
      pll_ref_select <= clock_config_reg[CFG_PLL_REF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // clock outputs

  // sampled path: sources above half the bus clock alias here; each output pin is registered on the bus clock
  clkout_if a_if ();
  clkout_if b_if ();

  assign a_if.sel = clock_config_reg[CFG_A_SEL_LO +: 2];
  assign a_if.pin_en = clock_config_reg[CFG_A_AF];
  assign a_if.src = {pllp_s, hs_s, ls_s, fast_s};
  assign b_if.sel = clock_config_reg[CFG_B_SEL_LO +: 2];
  assign b_if.pin_en = clock_config_reg[CFG_B_AF];
  assign b_if.src = {pllp_s, hs_s, audio_s, sys_s};

  clkout_mux u_mux_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .port(a_if.mux)
  );

  clkout_mux u_mux_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .port(b_if.mux)
  );

  assign clkout_a_pin_signal = a_if.pin_out;
  assign clkout_b_pin_signal = b_if.pin_out;

  ////////////////////////////////////////////////////////////////////////////////
  // rtc counter

  logic ls_prev, slow_prev, ls_tick, slow_tick, rtc_tick, rtc_stall;
  logic [1:0] rtc_src;

  assign rtc_src = backup_clock_ctrl_reg[BK_RTC_SRC_LO +: 2];
  assign ls_tick = ls_s & ~ls_prev;
  assign slow_tick = slow_s & ~slow_prev;

  always_comb begin
    rtc_tick = 1'b0;
    rtc_stall = 1'b0;
    case (rtc_src)
      RTC_SRC_LS_EXT: rtc_tick = ls_tick;
      RTC_SRC_SLOW_RC: begin
        // slow rc stops with main power; count is held, not cleared
        rtc_tick = slow_tick & power_s;
        rtc_stall = slow_tick & ~power_s;
      end
      default: rtc_tick = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ls_prev <= 1'b0;
      slow_prev <= 1'b0;
    end else if (ce) begin
      ls_prev <= ls_s;
      slow_prev <= slow_s;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rtc_count <= '0;
    end else if (ce) begin
      if (hit(OFS_RTC_COUNT)) begin
        rtc_count <= rtc_w[RTC_W-1:0];
      end else if (rtc_tick) begin
        rtc_count <= rtc_count + RTC_W'(1);
      end
    end
  end

  // sticky: a stall in the clearing cycle keeps the flag set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rtc_halted <= 1'b0;
    end else if (ce) begin
      if (rtc_stall) begin
        rtc_halted <= 1'b1;
      end else if (hit(OFS_STATUS) && st_w[ST_HALTED]) begin
        rtc_halted <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path

  logic ar_take, next_rvalid;
  logic [DATA_W-1:0] read_word;
  logic read_ok;

  assign ar_take = arvalid & arready;
  assign next_rvalid = ar_take | (rvalid & ~rready);

  always_comb begin
    read_word = '0;
    read_ok = 1'b1;
    case (araddr)
      OFS_CLOCK_CTRL: read_word = DATA_W'(clock_ctrl_reg);
      OFS_CLOCK_CONFIG: read_word = DATA_W'(clock_config_reg);
      OFS_BACKUP_CTRL: read_word = DATA_W'(backup_clock_ctrl_reg);
      OFS_CAPS: read_word = DATA_W'(max_sysclk_mhz(VARIANT));
      OFS_RTC_COUNT: read_word = DATA_W'(rtc_count);
      OFS_STATUS: begin
        read_word[ST_READY_LO +: 5] = ready_s;
        read_word[ST_POWER] = power_s;
        read_word[ST_HALTED] = rtc_halted;
      end
      default: read_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      arready <= ~next_rvalid;
      rvalid <= next_rvalid;
      if (ar_take) begin
        rdata <= read_word;
        rresp <= read_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

endmodule : clock_source_and_output_select

// ### sim/osc_model.sv
// far side model: oscillators, bypass clocks and main power
`timescale 1ns/100ps
module osc_model (
  // time base and bench controls
  input wire logic aclk,
  input wire logic run,
  input wire logic power,
  input wire logic [7:0] level,
  // towards the block
  input wire logic [4:0] osc_enable,
  output logic [7:0] src,
  output logic [4:0] osc_ready,
  output logic main_power_good
);
  logic [7:0] ticks = 8'h00;
  logic [4:0] warm = 5'h00;

  // oscillators report ready two cycles after enable, never instantly
  always @(posedge aclk) begin
    ticks <= ticks + 8'h01;
    warm <= osc_enable;
    osc_ready <= warm;
  end

  // order: sys, audio, pll p, slow rc, usb rc, fast rc, ls pin, hs pin
  // bypass or crystal both reach the block on the input pins
  always_comb begin
    src = run ? {ticks[0], ticks[2], ticks[0], ticks[1], ticks[3], ticks[0], ticks[4], ticks[2]}
              : level;
  end

  assign main_power_good = power;
endmodule : osc_model

// ### sim/clk_chk.sv
// port assertions for the clock source and output select block
`timescale 1ns/100ps
module clk_chk
  import clk_ctrl_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // oscillator controls
  input wire logic [4:0] osc_enable,
  input wire logic hs_osc_output_pin_drive,
  input wire logic ls_osc_output_pin_drive,
  input wire logic [1:0] ls_drive_strength,
  input wire logic hs_clock_from_pin,
  input wire logic ls_clock_from_pin
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////////
  reset_value_a: assert property (
    $rose(aresetn) |-> !bvalid && !rvalid ##1 osc_enable == 5'h02)
    else $error("wrong outputs after reset release");
  wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response not two cycles after take");
  one_write_a: assert property (awvalid && awready |=> !awready [*2])
    else $error("second write address taken too early");
  rd_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read data not one cycle after take");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before accept");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped before accept");
  err_data_a: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
    else $error("error read carries data");
  hs_bypass_a: assert property (hs_clock_from_pin |-> !hs_osc_output_pin_drive)
    else $error("fast output pin driven in bypass");
  ls_bypass_a: assert property (ls_clock_from_pin |-> !ls_osc_output_pin_drive)
    else $error("slow output pin driven in bypass");

  cover property (bvalid && bready && bresp == RESP_SLVERR);
  cover property (rvalid && rready && rresp == RESP_OKAY);
  cover property (ls_clock_from_pin && ls_drive_strength == DRIVE_HIGH);
endmodule : clk_chk

bind clock_source_and_output_select clk_chk u_clk_chk (.aclk, .aresetn, .awvalid, .awready,
  .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid,
  .rready, .osc_enable, .hs_osc_output_pin_drive, .ls_osc_output_pin_drive,
  .ls_drive_strength, .hs_clock_from_pin, .ls_clock_from_pin);

// ### sim/testbench.sv
// self-checking bench for the clock source and output select block
`timescale 1ns/100ps
module testbench
  import clk_ctrl_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0, power = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, level = 8'h00, src;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp, ls_drive_strength;
  logic awready, wready, bvalid, arready, rvalid, pll_ref_select, main_power_good;
  logic hs_osc_output_pin_drive, ls_osc_output_pin_drive, hs_clock_from_pin, ls_clock_from_pin;
  logic clkout_a_pin_signal, clkout_b_pin_signal;
  logic [4:0] osc_enable, osc_ready;
  int bad_count = 0, compares = 0, cycles = 0;

  always #5 aclk = ~aclk;

  clock_source_and_output_select #(.VARIANT(2'h1), .RTC_W(32)) u_clock_source_and_output_select (
    .aclk, .aresetn, .ce(1'b1), .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .hs_osc_input_pin(src[0]), .ls_osc_input_pin(src[1]), .rc_osc_fast(src[2]),
    .rc_osc_usb_rate(src[3]), .rc_osc_slow(src[4]), .pll_p_output(src[5]),
    .audio_pll_r_output(src[6]), .system_clock(src[7]), .osc_ready, .main_power_good,
    .osc_enable, .hs_osc_output_pin_drive, .ls_osc_output_pin_drive, .ls_drive_strength,
    .pll_ref_select, .hs_clock_from_pin, .ls_clock_from_pin, .clkout_a_pin_signal,
    .clkout_b_pin_signal);

  osc_model u_osc_model (.aclk, .run, .power, .level, .osc_enable, .src, .osc_ready,
    .main_power_good);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // response accept delayed on purpose so the hold checks see a stall
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, td;
    ta = 1'b0;
    td = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ta && td)) begin
      @(posedge aclk);
      if (!ta && awready === 1'b1) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (!td && wready === 1'b1) begin
        td = 1'b1;
        wvalid <= 1'b0;
      end
    end
    repeat (3) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    repeat (2) @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    @(posedge aclk);
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask : rdc

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc(OFS_CLOCK_CTRL, 32'h2, RESP_OKAY);
    rdc(OFS_CLOCK_CONFIG, 32'h0, RESP_OKAY);
    rdc(OFS_BACKUP_CTRL, 32'h0, RESP_OKAY);
    chk(32'(osc_enable), 32'h02);
    chk(32'(pll_ref_select), 32'(PLL_REF_FAST_RC));
  endtask : t_reset

  task automatic t_map();
    rdc(8'h18, 32'h0, RESP_SLVERR);
    wr(OFS_CAPS, 32'h0, RESP_SLVERR);
    wr(8'h18, 32'h1, RESP_SLVERR);
    rdc(OFS_CAPS, {24'h0, SYSCLK_MHZ_V1}, RESP_OKAY);
  endtask : t_map

  task automatic t_sources();
    wr(OFS_CLOCK_CTRL, 32'h7, RESP_OKAY);
    wr(OFS_BACKUP_CTRL, 32'h41, RESP_OKAY);
    chk(32'(osc_enable), 32'h1f);
    chk(32'({hs_osc_output_pin_drive, ls_osc_output_pin_drive}), 32'h3);
    wr(OFS_CLOCK_CTRL, 32'h9, RESP_OKAY);
    wr(OFS_BACKUP_CTRL, 32'h0f, RESP_OKAY);
    chk(32'(osc_enable), 32'h09);
    chk(32'({hs_osc_output_pin_drive, hs_clock_from_pin}), 32'h1);
    chk(32'({ls_osc_output_pin_drive, ls_clock_from_pin}), 32'h1);
    chk(32'(ls_drive_strength), 32'(DRIVE_HIGH));
    wr(OFS_CLOCK_CONFIG, 32'h1, RESP_OKAY);
    chk(32'(pll_ref_select), 32'(PLL_REF_HS_EXT));
    wr(OFS_CLOCK_CONFIG, 32'h0, RESP_OKAY);
    chk(32'(pll_ref_select), 32'(PLL_REF_FAST_RC));
  endtask : t_sources

  // one source high at a time while the pins are enabled, so only the selected one can light a pin; then all high with both pins gated
  task automatic t_clkout();
    logic [2:0] ia [4] = '{3'h2, 3'h1, 3'h0, 3'h5};
    logic [2:0] ib [4] = '{3'h7, 3'h6, 3'h0, 3'h5};
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CLOCK_CONFIG, {24'h0, 2'b11, s[1:0], s[1:0], 2'b00}, RESP_OKAY);
      level <= 8'h01 << ia[s];
      repeat (6) @(posedge aclk);
      chk(32'(clkout_a_pin_signal), 32'h1);
      chk(32'(clkout_b_pin_signal), 32'(ia[s] == ib[s]));
      level <= 8'h01 << ib[s];
      repeat (6) @(posedge aclk);
      chk(32'(clkout_b_pin_signal), 32'h1);
      chk(32'(clkout_a_pin_signal), 32'(ia[s] == ib[s]));
    end
    wr(OFS_CLOCK_CONFIG, 32'h3c, RESP_OKAY);
    level <= 8'hff;
    repeat (6) @(posedge aclk);
    chk(32'({clkout_a_pin_signal, clkout_b_pin_signal}), 32'h0);
  endtask : t_clkout

  task automatic t_rtc();
    logic [31:0] d;
    logic [1:0] r;
    power <= 1'b0;
    wr(OFS_BACKUP_CTRL, 32'h60, RESP_OKAY);
    wr(OFS_RTC_COUNT, 32'h5, RESP_OKAY);
    run <= 1'b1;
    repeat (40) @(posedge aclk);
    rdc(OFS_RTC_COUNT, 32'h5, RESP_OKAY);
    rd(OFS_STATUS, d, r);
    chk(32'(d[ST_HALTED]), 32'h1);
    chk(32'(d[5:0]), 32'h11);
    power <= 1'b1;
    repeat (40) @(posedge aclk);
    rd(OFS_RTC_COUNT, d, r);
    chk(32'(d > 32'h5 && d < 32'h20), 32'h1);
    wr(OFS_STATUS, 32'h40, RESP_OKAY);
    rd(OFS_STATUS, d, r);
    chk(32'(d[ST_HALTED]), 32'h0);
    chk(32'(d[5:0]), 32'h31);
    // slow crystal source keeps counting without main power, no halt flag
    wr(OFS_BACKUP_CTRL, 32'h11, RESP_OKAY);
    power <= 1'b0;
    wr(OFS_RTC_COUNT, 32'h0, RESP_OKAY);
    repeat (40) @(posedge aclk);
    rd(OFS_RTC_COUNT, d, r);
    chk(32'(d > 32'h0 && d < 32'h4), 32'h1);
    rd(OFS_STATUS, d, r);
    chk(32'(d[6:0]), 32'h09);
    power <= 1'b1;
    run <= 1'b0;
  endtask : t_rtc

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_map();
    t_sources();
    t_clkout();
    t_rtc();
    results();
  end
endmodule : testbench
